// file: bench/ptt_dev_model.sv
// Behavioural model of the double-buffered tile transfer device.
// Assumes one ref_clk; read data holds until the next access.
`timescale 1ns/1ps
module ptt_dev_model import ptt_pkg::*; (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Device pins
	input  wire logic [1:0]  dev_sel,
	input  wire logic [15:0] dev_wdata,
	input  wire logic        dev_wr,
	input  wire logic        dev_rd,
	input  wire logic        dev_step,
	output logic [15:0]      dev_rdata,
	output logic             dev_busy
);
	ptt_csr_t    csr_reg;
	ptt_a0_t     a0_reg;
	logic [15:0] tile_reg;
	logic [15:0] buf_mem [2][32];
	logic [15:0] store_mem [32];
	int          left;
	int          n;

	// Registers, buffers and transfer timer; an odd tile number runs slow
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			csr_reg = '0;
			a0_reg = '0;
			tile_reg = 16'h0;
			dev_rdata <= 16'h0;
			dev_busy <= 1'b0;
			left = 0;
		end else begin
			if (left > 1) begin
				left--;
			end else if (left == 1) begin
				left = 0;
				dev_busy <= 1'b0;
				csr_reg.go_done = 1'b0;
				n = a0_reg.size_select ? 16 : 32;
				for (int i = 0; i < n; i++) begin
					if (csr_reg.csr_write_not_read)
						store_mem[i] = buf_mem[!csr_reg.buffer_select][i];
					else
						buf_mem[!csr_reg.buffer_select][i] = store_mem[i];
				end
			end
			if (dev_rd) begin
				case (dev_sel)
					2'h0: dev_rdata <= csr_reg;
					2'h1: dev_rdata <= a0_reg;
					2'h2: dev_rdata <= tile_reg;
					default: dev_rdata <= buf_mem[csr_reg.buffer_select][csr_reg.buffer_pointer];
				endcase
			end
			if (dev_wr) begin
				case (dev_sel)
					2'h0: begin
						csr_reg = dev_wdata;
						if (dev_wdata[15]) begin
							dev_busy <= 1'b1;
							left = 68 + (dev_wdata[14] ? 0 : 24) + (a0_reg.size_select ? 0 : 16)
								+ (tile_reg[0] ? 150 : 0);
						end
					end
					2'h1: a0_reg = dev_wdata;
					2'h2: tile_reg = dev_wdata;
					default: buf_mem[csr_reg.buffer_select][csr_reg.buffer_pointer] = dev_wdata;
				endcase
			end
			if ((dev_wr || dev_rd) && dev_step && dev_sel == 2'h3)
				csr_reg.buffer_pointer = csr_reg.buffer_pointer + 5'h1;
		end
	end
endmodule

// file: bench/ptt_host_bench.sv
// Self-checking bench of the tile transfer host against the device model.
// Assumes the register map and command bits of the shared defines.
`timescale 1ns/1ps
`include "ptt_defs.svh"
module ptt_host_bench;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [4:0]  reg_addr = 5'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        xfer_active, dev_wr, dev_rd, dev_step, dev_busy, rd_d = 1'b0;
	logic [1:0]  dev_sel;
	logic [15:0] dev_wdata, dev_rdata;
	logic [15:0] pix [32];
	logic [63:0] notes [$];
	logic [31:0] shp [8] = '{32'h00000460, 32'h00014A05, 32'h00014F9C, 32'h00004D04,
		32'h00004404, 32'h00000C00, 32'h00004000, 32'h00000820};
	int          mismatches = 0, checked = 0, cyc = 0, i, k;

	ptt_host ptt_host_inst (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_active(xfer_active), .dev_sel(dev_sel),
		.dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_step(dev_step), .dev_rdata(dev_rdata),
		.dev_busy(dev_busy));
	ptt_dev_model ptt_dev_model_inst (.ref_clk(ref_clk), .resetn(resetn), .dev_sel(dev_sel),
		.dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_step(dev_step), .dev_rdata(dev_rdata),
		.dev_busy(dev_busy));

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// A hang is cut short well beyond the longest expected run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// Strobes are one cycle; the tail lets a one-access write command go idle before the next write
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		repeat (5) @(posedge ref_clk);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back({m, e});
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wait_idle;
		repeat (4) @(posedge ref_clk);
		for (k = 0; k < 2000 && xfer_active !== 1'b0; k++)
			@(posedge ref_clk);
		repeat (6) @(posedge ref_clk); // A swap after a read still runs here
	endtask

	task automatic cmp_rd(input logic [63:0] nt);
		checked++;
		if (((reg_rdata ^ nt[31:0]) & nt[63:32]) !== 32'h0) begin
			mismatches++;
			$display("ERROR reg_rdata expected %h seen %h", nt[31:0], reg_rdata);
		end
	endtask

	// Read answers stand only in the cycle after the strobe; look at them mid-cycle
	always @(posedge ref_clk) rd_d <= reg_rd;
	always @(negedge ref_clk) if (rd_d) cmp_rd(notes.pop_front());

	initial begin
		i = $urandom(32'h5EC3C06F);
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(`PTT_HR_CFG, 32'h0, 32'hFFFFFFFF);
		rd(`PTT_HR_STAT, 32'h0, 32'h0000003F);
		rd(5'h14, 32'h0, 32'hFFFFFFFF);
		i = $urandom & 32'h00F74FFF;
		wr(`PTT_HR_CFG, i);
		rd(`PTT_HR_CFG, i, 32'h00F74FFF);
		i = $urandom & 32'h0000FFFF;
		wr(`PTT_HR_TILE, i);
		rd(`PTT_HR_TILE, i, 32'h0000FFFF);
		$display("test registers done");
		// Fill a buffer, write it to memory and refuse a tile change meanwhile
		wr(`PTT_HR_CFG, 32'h00040000);
		wr(`PTT_HR_CMD, 32'h8);
		for (i = 0; i < 32; i++) begin
			pix[i] = $urandom;
			wr(`PTT_HR_PIX, {16'h0, pix[i]});
		end
		i = $urandom & 32'h0000FFFF;
		wr(`PTT_HR_TILE, i);
		wr(`PTT_HR_CFG, 32'h00050400 | (($urandom & 32'h1F) << 5));
		wr(`PTT_HR_CMD, 32'h1);
		wr(`PTT_HR_TILE, 32'h0);
		wait_idle();
		rd(`PTT_HR_STAT, 32'h2, 32'hF);
		rd(`PTT_HR_TILE, i, 32'h0000FFFF);
		wr(`PTT_HR_STAT, 32'h1E);
		// Read the same pixels back with a swap after the read, then fetch them
		wr(`PTT_HR_CFG, 32'h00060400);
		wr(`PTT_HR_CMD, 32'h1);
		wait_idle();
		rd(`PTT_HR_STAT, 32'h2, 32'hF);
		wr(`PTT_HR_STAT, 32'h1E);
		wr(`PTT_HR_CMD, 32'h8);
		for (i = 0; i < 32; i++) begin
			wr(`PTT_HR_CMD, 32'h4);
			repeat (8) @(posedge ref_clk);
			rd(`PTT_HR_PIX, {16'h0, pix[i]}, 32'h0000FFFF);
		end
		$display("test round trip done");
		// Four legal shapes in both directions first, then four illegal ones as reads
		for (i = 0; i < 8; i++) begin
			wr(`PTT_HR_CFG, shp[i]);
			wr(`PTT_HR_CMD, 32'h1);
			wait_idle();
			rd(`PTT_HR_STAT, i < 4 ? 32'h2 : 32'h4, i < 4 ? 32'h7 : 32'h5);
			wr(`PTT_HR_STAT, 32'h1E);
		end
		$display("test shapes done");
		// Two legal writes and two unswapped reads leave select low; a toggle raises it
		wr(`PTT_HR_CMD, 32'h2);
		repeat (8) @(posedge ref_clk);
		rd(`PTT_HR_STAT, 32'h20, 32'h21);
		repeat (4) @(posedge ref_clk);
		$display("test toggle done");
		tally_and_finish();
	end
endmodule

// file: bench/ptt_host_sva.sv
// Checker of the tile transfer host: device pin order and fields.
// Assumes the device raises busy only after a go write.
`timescale 1ns/1ps
module ptt_host_sva (
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic [4:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        xfer_active,
	input wire logic [1:0]  dev_sel,
	input wire logic [15:0] dev_wdata,
	input wire logic        dev_wr,
	input wire logic        dev_rd,
	input wire logic        dev_step,
	input wire logic [15:0] dev_rdata,
	input wire logic        dev_busy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic       rnw_reg;
	logic       pp_reg;
	logic [9:0] go_cnt;
	wire        go_wr = dev_wr && dev_sel == 2'h0 && dev_wdata[15];
	wire        a0_wr = dev_wr && dev_sel == 2'h1;

	// Last direction and buffer select sent, cycles since the last go
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rnw_reg <= 1'b0;
			pp_reg <= 1'b0;
			go_cnt <= 10'h3FF;
		end else begin
			if (a0_wr)
				rnw_reg <= dev_wdata[12];
			if (dev_wr && dev_sel == 2'h0)
				pp_reg <= dev_wdata[5];
			go_cnt <= go_wr ? 10'h0 : (go_cnt == 10'h3FF ? go_cnt : go_cnt + 10'h1);
		end
	end

	property p_dir_agree; go_wr |-> dev_wdata[14] == !rnw_reg; endproperty
	a_dir_agree: assert property (p_dir_agree) else $error("direction bits disagree");
	property p_swap_write; go_wr && dev_wdata[14] |-> dev_wdata[5] != pp_reg; endproperty
	a_swap_write: assert property (p_swap_write) else $error("write started without swap");
	property p_keep_read; go_wr && !dev_wdata[14] |-> dev_wdata[5] == pp_reg; endproperty
	a_keep_read: assert property (p_keep_read) else $error("read start swapped buffers");
	property p_csr_idle; dev_wr && dev_sel == 2'h0 |-> !dev_busy; endproperty
	a_csr_idle: assert property (p_csr_idle) else $error("csr written while busy");
	property p_addr_idle; dev_wr && (dev_sel == 2'h1 || dev_sel == 2'h2) |-> !dev_busy; endproperty
	a_addr_idle: assert property (p_addr_idle) else $error("address written while busy");
	property p_a0_rsv; a0_wr |-> dev_wdata[15] == 1'b0 && dev_wdata[13] == 1'b0; endproperty
	a_a0_rsv: assert property (p_a0_rsv) else $error("reserved address bit set");
	property p_shape_lin;
		a0_wr && (dev_wdata[10] ^ dev_wdata[11]) |->
			(dev_wdata[10] ? dev_wdata[3:0] : dev_wdata[8:5]) == 4'h0
			&& (dev_wdata[14] || (dev_wdata[10] ? dev_wdata[4] : dev_wdata[9]) == 1'b0);
	endproperty
	a_shape_lin: assert property (p_shape_lin) else $error("bad linear start");
	property p_shape_sq;
		a0_wr |-> (dev_wdata[10] || dev_wdata[11]) && (!(dev_wdata[10] && dev_wdata[11])
			|| (dev_wdata[14] && dev_wdata[1:0] == 2'h0 && dev_wdata[6:5] == 2'h0));
	endproperty
	a_shape_sq: assert property (p_shape_sq) else $error("bad shape");
	property p_go_active; go_wr |-> xfer_active ##1 xfer_active; endproperty
	a_go_active: assert property (p_go_active) else $error("go without active engine");
	property p_min_time; $fell(xfer_active) |-> go_cnt >= 10'h044; endproperty
	a_min_time: assert property (p_min_time) else $error("transfer ended too early");
	property p_step_data; dev_step |-> (dev_wr || dev_rd) && dev_sel == 2'h3; endproperty
	a_step_data: assert property (p_step_data) else $error("step outside data access");
	cover property (go_wr && dev_wdata[14]);
	cover property (go_wr && !dev_wdata[14]);
	cover property (dev_step && dev_wr);
endmodule

bind ptt_host ptt_host_sva ptt_host_sva_inst (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_active(xfer_active),
	.dev_sel(dev_sel), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_step(dev_step),
	.dev_rdata(dev_rdata), .dev_busy(dev_busy));

// file: core/ptt_dev_access.sv
// Single-access master for the device's scalar register pins.
// Assumes the device holds its read data until the next access.
`timescale 1ns/1ps
`include "ptt_defs.svh"
module ptt_dev_access import ptt_pkg::*; (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         resetn,
	// Request from the sequencer
	input  wire logic         req,
	input  wire ptt_dev_req_t req_data,
	output logic              done,
	output logic [15:0]       rdata,
	// Device pins
	output logic [1:0]        dev_sel,
	output logic [15:0]       dev_wdata,
	output logic              dev_wr,
	output logic              dev_rd,
	output logic              dev_step,
	input  wire logic [15:0]  dev_rdata
);
	logic [15:0] rd_meta_reg;
	logic [15:0] rd_sync_reg;
	logic        active_reg;
	logic        is_wr_reg;
	logic [2:0]  cnt_reg;

	// Read data arrive from outside the clock domain
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rd_meta_reg <= 16'h0000;
			rd_sync_reg <= 16'h0000;
		end else begin
			rd_meta_reg <= dev_rdata;
			rd_sync_reg <= rd_meta_reg;
		end
	end

	// Strobes last one cycle; a read waits out the synchroniser
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dev_sel    <= 2'h0;
			dev_wdata  <= 16'h0000;
			dev_wr     <= 1'b0;
			dev_rd     <= 1'b0;
			dev_step   <= 1'b0;
			active_reg <= 1'b0;
			is_wr_reg  <= 1'b0;
			cnt_reg    <= 3'h0;
			done       <= 1'b0;
			rdata      <= 16'h0000;
		end else begin
			dev_wr   <= 1'b0;
			dev_rd   <= 1'b0;
			dev_step <= 1'b0;
			done     <= 1'b0;
			if (req && !active_reg) begin
				dev_sel    <= req_data.sel;
				dev_wdata  <= req_data.wdata;
				dev_wr     <= req_data.we;
				dev_rd     <= !req_data.we;
				dev_step   <= req_data.step;
				is_wr_reg  <= req_data.we;
				cnt_reg    <= req_data.we ? 3'h1 : 3'(`PTT_DEV_RD_LAT);
				active_reg <= 1'b1;
			end else if (active_reg) begin
				if (cnt_reg == 3'h1) begin
					done       <= 1'b1;
					active_reg <= 1'b0;
					if (!is_wr_reg)
						rdata <= rd_sync_reg;
				end else begin
					cnt_reg <= cnt_reg - 3'h1;
				end
			end
		end
	end
endmodule

// file: core/ptt_host.sv
// Host controller for the double-buffered pixel tile transfer engine.
// Drives the device's control/status, address, tile and data registers
// over its scalar pins; software orders it through a plain register port.
// Assumes the device pins are asynchronous to ref_clk.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "ptt_defs.svh"
module ptt_host import ptt_pkg::*; (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Software register port
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Engine state
	output logic             xfer_active,
	// Device scalar bus pins
	output logic [1:0]       dev_sel,
	output logic [15:0]      dev_wdata,
	output logic             dev_wr,
	output logic             dev_rd,
	output logic             dev_step,
	input  wire logic [15:0] dev_rdata,
	input  wire logic        dev_busy
);
	ptt_state_t   state_reg;
	logic [31:0]  cfg_reg;
	logic [15:0]  tile_reg;
	logic [15:0]  pix_wr_reg;
	logic [15:0]  pix_rd_reg;
	logic         sel_reg;
	logic [4:0]   ptr_reg;
	logic         done_flag_reg;
	logic         shape_err_reg;
	logic         refused_reg;
	logic         timeout_reg;
	logic         busy_meta_reg;
	logic         busy_sync_reg;
	logic         issued_reg;
	logic         req_reg;
	ptt_dev_req_t req_data_reg;
	logic [9:0]   wait_reg;
	logic [9:0]   wdog_reg;
	logic         acc_done;
	logic [15:0]  acc_rdata;
	logic         shape_ok;
	ptt_a0_t      a0_img;
	ptt_csr_t     csr_img;
	logic         dir_write;
	logic         auto_incr;
	logic         idle;
	logic         host_wr;
	logic [9:0]   min_wait;
	logic         cmd_start;
	logic         cmd_toggle;
	logic         cmd_fetch;
	logic         cmd_setptr;
	logic         cmd_pix;
	logic         any_cmd;
	logic         ev_done;
	logic         ev_shape;
	logic         ev_refuse;
	logic         ev_timeout;
	logic         clr_w1c;

	assign dir_write = cfg_reg[`PTT_CFG_DIR_WRITE];
	assign auto_incr = cfg_reg[`PTT_CFG_AUTO_INCR];
	assign idle      = (state_reg == PTT_IDLE);
	assign host_wr   = reg_wr && !reg_rd;

	// Both direction bits derive from one setting, so they never disagree
	always_comb begin
		a0_img                     = ptt_a0_t'(cfg_reg[15:0]);
		a0_img.rsv_15              = 1'b0;
		a0_img.rsv_13              = 1'b0;
		a0_img.addr_read_not_write = !dir_write;
	end

	// Csr image with direction from the configuration; go is filled in per access
	always_comb begin
		csr_img                    = ptt_csr_t'(16'h0000);
		csr_img.buffer_pointer     = ptr_reg;
		csr_img.buffer_select      = sel_reg;
		{csr_img.channel3_enable, csr_img.channel2_enable,
			csr_img.channel1_enable, csr_img.channel0_enable} = cfg_reg[`PTT_CFG_CHAN_LSB +: 4];
		csr_img.csr_write_not_read = dir_write;
	end

	ptt_shape_check u_shape (
		.a0       (ptt_a0_t'(cfg_reg[15:0])),
		.shape_ok (shape_ok)
	);

	ptt_dev_access u_acc (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.req       (req_reg),
		.req_data  (req_data_reg),
		.done      (acc_done),
		.rdata     (acc_rdata),
		.dev_sel   (dev_sel),
		.dev_wdata (dev_wdata),
		.dev_wr    (dev_wr),
		.dev_rd    (dev_rd),
		.dev_step  (dev_step),
		.dev_rdata (dev_rdata)
	);

	// Least transfer time for the chosen shape and direction
	assign min_wait = 10'(`PTT_C_WR16_MIN)
		+ (dir_write ? 10'h000 : 10'(`PTT_C_RD_EXTRA))
		+ (a0_img.size_select ? 10'h000 : 10'(`PTT_C_32_EXTRA));

	// Command decode from the software port
	assign cmd_start  = host_wr && (reg_addr == `PTT_HR_CMD) && reg_wdata[`PTT_CMD_START];
	assign cmd_toggle = host_wr && (reg_addr == `PTT_HR_CMD) && reg_wdata[`PTT_CMD_TOGGLE];
	assign cmd_fetch  = host_wr && (reg_addr == `PTT_HR_CMD) && reg_wdata[`PTT_CMD_FETCH];
	assign cmd_setptr = host_wr && (reg_addr == `PTT_HR_CMD) && reg_wdata[`PTT_CMD_SETPTR];
	assign cmd_pix    = host_wr && (reg_addr == `PTT_HR_PIX);
	assign any_cmd    = cmd_start || cmd_toggle || cmd_fetch || cmd_setptr || cmd_pix;
	assign clr_w1c    = host_wr && (reg_addr == `PTT_HR_STAT);

	// Events feeding the sticky status bits
	assign ev_refuse  = any_cmd && !idle;
	assign ev_shape   = cmd_start && idle && !shape_ok;
	assign ev_done    = (state_reg == PTT_CHECK) && !acc_rdata[`PTT_CSR_GO_BIT] && !busy_sync_reg;
	assign ev_timeout = (state_reg == PTT_CHECK) && !ev_done && (wdog_reg == 10'h000);

	// Device busy comes from a pin
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			busy_meta_reg <= 1'b0;
			busy_sync_reg <= 1'b0;
		end else begin
			busy_meta_reg <= dev_busy;
			busy_sync_reg <= busy_meta_reg;
		end
	end

	// Configuration and tile number are frozen while a transfer runs
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_reg    <= `PTT_CFG_RESET;
			tile_reg   <= 16'h0000;
			pix_wr_reg <= 16'h0000;
		end else if (host_wr && idle) begin
			if (reg_addr == `PTT_HR_CFG)
				cfg_reg <= reg_wdata;
			if (reg_addr == `PTT_HR_TILE)
				tile_reg <= reg_wdata[15:0];
			if (reg_addr == `PTT_HR_PIX)
				pix_wr_reg <= reg_wdata[15:0];
		end
	end

	// Sticky flags: a set in the clearing cycle wins
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			done_flag_reg <= 1'b0;
			shape_err_reg <= 1'b0;
			refused_reg   <= 1'b0;
			timeout_reg   <= 1'b0;
		end else begin
			done_flag_reg <= ev_done    || (done_flag_reg && !(clr_w1c && reg_wdata[1]));
			shape_err_reg <= ev_shape   || (shape_err_reg && !(clr_w1c && reg_wdata[2]));
			refused_reg   <= ev_refuse  || (refused_reg   && !(clr_w1c && reg_wdata[3]));
			timeout_reg   <= ev_timeout || (timeout_reg   && !(clr_w1c && reg_wdata[4]));
		end
	end

	// Shadow of the buffer select and pointer held in the device csr
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sel_reg <= 1'b0;
			ptr_reg <= 5'h00;
		end else if (idle) begin
			if (cmd_start && shape_ok && dir_write)
				sel_reg <= !sel_reg;
			else if (cmd_toggle)
				sel_reg <= !sel_reg;
			if (cmd_setptr)
				ptr_reg <= reg_wdata[`PTT_CMD_PTR_LSB +: 5];
			else if (cmd_start && shape_ok)
				ptr_reg <= 5'h00;
		end else if (ev_done && !dir_write && cfg_reg[`PTT_CFG_AUTO_SWAP]) begin
			sel_reg <= !sel_reg;
			ptr_reg <= 5'h00;
		end else if (acc_done && auto_incr
			&& (state_reg == PTT_PIXRD || state_reg == PTT_PIXWR)) begin
			ptr_reg <= ptr_reg + 5'h01;
		end
	end

	// Sequencer: each access state issues one request and waits its answer
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= PTT_IDLE;
			issued_reg   <= 1'b0;
			req_reg      <= 1'b0;
			req_data_reg <= ptt_dev_req_t'(20'h00000);
			wait_reg     <= 10'h000;
			wdog_reg     <= 10'h000;
			pix_rd_reg   <= 16'h0000;
			xfer_active  <= 1'b0;
		end else begin
			req_reg <= 1'b0;
			if (acc_done)
				issued_reg <= 1'b0;
			case (state_reg)
				PTT_IDLE: begin
					xfer_active <= 1'b0;
					if (cmd_start && shape_ok) begin
						state_reg   <= PTT_FREE;
						xfer_active <= 1'b1;
					end else if (cmd_toggle || cmd_setptr) begin
						state_reg <= PTT_CSRW;
					end else if (cmd_fetch) begin
						state_reg <= PTT_PIXRD;
					end else if (cmd_pix) begin
						state_reg <= PTT_PIXWR;
					end
				end
				PTT_FREE: begin
					if (!busy_sync_reg)
						state_reg <= PTT_TILE;
				end
				PTT_TILE: begin
					if (!issued_reg) begin
						req_reg      <= 1'b1;
						issued_reg   <= 1'b1;
						req_data_reg <= '{we: 1'b1, sel: `PTT_DEV_A1, step: 1'b0, wdata: tile_reg};
					end else if (acc_done) begin
						state_reg <= PTT_ADDR;
					end
				end
				PTT_ADDR: begin
					if (!issued_reg) begin
						req_reg      <= 1'b1;
						issued_reg   <= 1'b1;
						req_data_reg <= '{we: 1'b1, sel: `PTT_DEV_A0, step: 1'b0, wdata: 16'(a0_img)};
					end else if (acc_done) begin
						state_reg <= PTT_GO;
					end
				end
				PTT_GO: begin
					if (!issued_reg) begin
						req_reg      <= 1'b1;
						issued_reg   <= 1'b1;
						req_data_reg <= '{we: 1'b1, sel: `PTT_DEV_CSR, step: 1'b0,
							wdata: {1'b1, 15'(csr_img)}};
					end else if (acc_done) begin
						state_reg <= PTT_MINW;
						wait_reg  <= min_wait;
						wdog_reg  <= 10'(`PTT_C_WDOG);
					end
				end
				PTT_MINW: begin
					if (wdog_reg != 10'h000)
						wdog_reg <= wdog_reg - 10'h001;
					if (wait_reg <= 10'h001)
						state_reg <= PTT_POLL;
					else
						wait_reg <= wait_reg - 10'h001;
				end
				PTT_POLL: begin
					if (wdog_reg != 10'h000)
						wdog_reg <= wdog_reg - 10'h001;
					if (!issued_reg) begin
						req_reg      <= 1'b1;
						issued_reg   <= 1'b1;
						req_data_reg <= '{we: 1'b0, sel: `PTT_DEV_CSR, step: 1'b0, wdata: 16'h0000};
					end else if (acc_done) begin
						state_reg <= PTT_CHECK;
					end
				end
				PTT_CHECK: begin
					if (ev_done) begin
						xfer_active <= 1'b0;
						if (!dir_write && cfg_reg[`PTT_CFG_AUTO_SWAP])
							state_reg <= PTT_CSRW;
						else
							state_reg <= PTT_IDLE;
					end else if (ev_timeout) begin
						xfer_active <= 1'b0;
						state_reg   <= PTT_IDLE;
					end else begin
						state_reg <= PTT_POLL;
					end
				end
				PTT_CSRW: begin
					if (!issued_reg) begin
						req_reg      <= 1'b1;
						issued_reg   <= 1'b1;
						req_data_reg <= '{we: 1'b1, sel: `PTT_DEV_CSR, step: 1'b0,
							wdata: {1'b0, 15'(csr_img)}};
					end else if (acc_done) begin
						state_reg <= PTT_IDLE;
					end
				end
				PTT_PIXRD: begin
					if (!issued_reg) begin
						req_reg      <= 1'b1;
						issued_reg   <= 1'b1;
						req_data_reg <= '{we: 1'b0, sel: `PTT_DEV_DATA, step: auto_incr, wdata: 16'h0000};
					end else if (acc_done) begin
						pix_rd_reg <= acc_rdata;
						state_reg  <= PTT_IDLE;
					end
				end
				PTT_PIXWR: begin
					if (!issued_reg) begin
						req_reg      <= 1'b1;
						issued_reg   <= 1'b1;
						req_data_reg <= '{we: 1'b1, sel: `PTT_DEV_DATA, step: auto_incr, wdata: pix_wr_reg};
					end else if (acc_done) begin
						state_reg <= PTT_IDLE;
					end
				end
				default: begin
					state_reg <= PTT_IDLE;
				end
			endcase
		end
	end

	// Read data stand in the cycle after the read strobe only
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd && !reg_wr) begin
			case (reg_addr)
				`PTT_HR_CFG:  reg_rdata <= cfg_reg;
				`PTT_HR_TILE: reg_rdata <= {16'h0000, tile_reg};
				`PTT_HR_STAT: reg_rdata <= {15'h0000, busy_sync_reg, 3'h0, ptr_reg, 2'h0, sel_reg,
					timeout_reg, refused_reg, shape_err_reg, done_flag_reg, !idle};
				`PTT_HR_PIX:  reg_rdata <= {16'h0000, pix_rd_reg};
				default:      reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// file: core/ptt_shape_check.sv
// Checks that a requested access shape lies inside one tile.
// Purely combinational; the caller uses its verdict unregistered.
`timescale 1ns/1ps
module ptt_shape_check import ptt_pkg::*; (
	// Requested in-tile address and mode
	input  wire ptt_a0_t a0,
	// Verdict
	output logic         shape_ok
);
	logic x_on_16;
	logic y_on_16;

	// A half span starts at pixel 0 or 16
	assign x_on_16 = (a0.x_coordinate[3:0] == 4'h0);
	assign y_on_16 = (a0.y_coordinate[3:0] == 4'h0);

	// Only the five shapes are accepted
	always_comb begin
		shape_ok = 1'b0;
		case ({a0.vertical_access, a0.horizontal_access})
			2'b01: begin
				shape_ok = a0.size_select ? x_on_16 : (a0.x_coordinate == 5'h00);
			end
			2'b10: begin
				shape_ok = a0.size_select ? y_on_16 : (a0.y_coordinate == 5'h00);
			end
			2'b11: begin
				shape_ok = a0.size_select && (a0.x_coordinate[1:0] == 2'h0)
					&& (a0.y_coordinate[1:0] == 2'h0);
			end
			default: begin
				shape_ok = 1'b0;
			end
		endcase
		if (a0.rsv_13 || a0.rsv_15)
			shape_ok = 1'b0;
	end
endmodule

// file: pkg/ptt_defs.svh
// Constants of the pixel tile transfer controller: host register map,
// device register selectors, field positions and transfer timing.
// Assumes a 40 MHz ref_clk; included by bare name where needed.
`ifndef PTT_DEFS_SVH
`define PTT_DEFS_SVH

// Host-side register offsets (byte addresses)
`define PTT_HR_CFG        5'h00
`define PTT_HR_TILE       5'h04
`define PTT_HR_CMD        5'h08
`define PTT_HR_STAT       5'h0C
`define PTT_HR_PIX        5'h10

// Host configuration fields
`define PTT_CFG_DIR_WRITE 16
`define PTT_CFG_AUTO_SWAP 17
`define PTT_CFG_AUTO_INCR 18
`define PTT_CFG_CHAN_LSB  20
`define PTT_CFG_RESET     32'h0000_0000

// Host command bits
`define PTT_CMD_START     0
`define PTT_CMD_TOGGLE    1
`define PTT_CMD_FETCH     2
`define PTT_CMD_SETPTR    3
`define PTT_CMD_PTR_LSB   8

// Device register selectors on the scalar bus pins
`define PTT_DEV_CSR       2'h0
`define PTT_DEV_A0        2'h1
`define PTT_DEV_A1        2'h2
`define PTT_DEV_DATA      2'h3

// Device field positions
`define PTT_CSR_GO_BIT    15
`define PTT_TILE_PIXELS   32

// Cycles from the read strobe to sampling the synchronised read data
`define PTT_DEV_RD_LAT    4

// Transfer timing in ns and the clock rate
`define PTT_CLK_MHZ       40
`define PTT_T_WR16_MIN_NS 1700
`define PTT_T_RD_EXTRA_NS 600
`define PTT_T_32_EXTRA_NS 400
`define PTT_T_XFER_MAX_NS 4600
`define PTT_WDOG_FACTOR   4

// Derived cycle counts: least times round up, the longest rounds down
`define PTT_C_WR16_MIN    ((`PTT_T_WR16_MIN_NS * `PTT_CLK_MHZ + 999) / 1000)
`define PTT_C_RD_EXTRA    ((`PTT_T_RD_EXTRA_NS * `PTT_CLK_MHZ + 999) / 1000)
`define PTT_C_32_EXTRA    ((`PTT_T_32_EXTRA_NS * `PTT_CLK_MHZ + 999) / 1000)
`define PTT_C_XFER_MAX    ((`PTT_T_XFER_MAX_NS * `PTT_CLK_MHZ) / 1000)
`define PTT_C_WDOG        (`PTT_C_XFER_MAX * `PTT_WDOG_FACTOR)

`endif

// file: pkg/ptt_pkg.sv
// Types of the pixel tile transfer controller: device register images,
// the device access request and the sequencer states.
// Field positions follow the device's control/status and address registers.
package ptt_pkg;

	// Device control/status register image
	typedef struct packed {
		logic       go_done;
		logic       csr_write_not_read;
		logic [1:0] rsv_13_12;
		logic       channel3_enable;
		logic       channel2_enable;
		logic       channel1_enable;
		logic       channel0_enable;
		logic [1:0] rsv_7_6;
		logic       buffer_select;
		logic [4:0] buffer_pointer;
	} ptt_csr_t;

	// Device in-tile address and access mode image
	typedef struct packed {
		logic       rsv_15;
		logic       size_select;
		logic       rsv_13;
		logic       addr_read_not_write;
		logic       vertical_access;
		logic       horizontal_access;
		logic [4:0] y_coordinate;
		logic [4:0] x_coordinate;
	} ptt_a0_t;

	// One access to a device register
	typedef struct packed {
		logic        we;
		logic [1:0]  sel;
		logic        step;
		logic [15:0] wdata;
	} ptt_dev_req_t;

	// Sequencer states
	typedef enum logic [3:0] {
		PTT_IDLE   = 4'b0000,
		PTT_FREE   = 4'b0001,
		PTT_TILE   = 4'b0010,
		PTT_ADDR   = 4'b0011,
		PTT_GO     = 4'b0100,
		PTT_MINW   = 4'b0101,
		PTT_POLL   = 4'b0110,
		PTT_CHECK  = 4'b0111,
		PTT_CSRW   = 4'b1000,
		PTT_PIXRD  = 4'b1001,
		PTT_PIXWR  = 4'b1010
	} ptt_state_t;

endpackage
